// ### common/itc_consts.svh
// offsets, field positions, reset values and timing counts of the integration test control
// assumes inclusion by bare name from the package and the design files
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH

`define ITC_OFF_CTRL      12'h000
`define ITC_OFF_INPUT     12'h004
`define ITC_OFF_INDEX     12'h008
`define ITC_OFF_TESTOUT   12'h00C
`define ITC_OFF_OBSERVE   12'h010
`define ITC_OFF_WDATA     12'h014
`define ITC_OFF_RDATA     12'h018

`define ITC_BIT_ENABLE    0
`define ITC_BIT_DRIVE     1
`define ITC_BIT_WNR       2
`define ITC_BIT_UNIT      3
`define ITC_ACC_LSB       4
`define ITC_ACC_MSB       8
`define ITC_BIT_SECDBG    0

`define ITC_CTRL_MASK     32'h0000_01FF
`define ITC_CTRL_RESET    32'h0000_0000
`define ITC_WORD_RESET    32'h0000_0000
`define ITC_IO_RESET      8'h00

`define ITC_IO_WIDTH      8
`define ITC_TBU_NUM_BITS  3
`define ITC_RAM_LATENCY   1

`endif

// ### common/itc_pkg.sv
// types shared by the integration test control files
// assumes itc_consts.svh on the include path
`include "itc_consts.svh"

package itc_pkg;
    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;
    typedef logic [4:0]  acc_t;
    typedef logic [`ITC_IO_WIDTH-1:0] io_t;

    typedef enum logic [2:0] {
        RAM_IDLE    = 3'b001,
        RAM_ISSUE   = 3'b010,
        RAM_CAPTURE = 3'b100
    } ram_state_e;
endpackage

// ### rtl/integration_test_control.sv
// integration test control: apb registers, pin override and test RAM access
// assumes an apb master on pclk and a test RAM answering one cycle after a request
//
// Summary of operation
// - Bit 0 of the control register enables integration mode and resets to 0.
// - In integration mode software drives the block outputs and observes its inputs.
// - Bit 1 enables driving the RAM bus and reading the RAM, resetting to 0.
// - Bit 2 picks read (0) or write (1) of the selected RAM at the held index.
// - Bit 3 selects the control unit RAMs (0) or a buffer unit RAM (1).
// - With the control unit selected, access bits 8 to 5 are ignored.
// - With the control unit selected, access bit 4 picks address cache (0) or macro tlb (1).
// - With a buffer unit selected, access bits 8 to 4 give its number, low bits only.
// - Bit 0 of the input register shows the secure debug enable pin level.
// - With RAM drive on and the control unit selected, the index holds way and index.
`include "itc_consts.svh"

module integration_test_control
    import itc_pkg::*;
(
    input  wire logic  pclk,        // bus clock, 25 MHz
    input  wire logic  presetn,     // async reset, active low
    input  wire logic  psel,        // apb select
    input  wire logic  penable,     // apb enable
    input  wire logic  pwrite,      // apb direction
    input  wire addr_t paddr,       // apb byte address
    input  wire word_t pwdata,      // apb write data
    output word_t      prdata,      // apb read data
    output logic       pready,      // apb ready
    output logic       pslverr,     // apb error on unmapped address
    input  wire logic  spniden,     // secure debug enable pin
    input  wire io_t   core_out,    // functional outputs from the core
    input  wire io_t   core_in,     // block inputs seen by the core
    output io_t        pin_out,     // outputs toward the system
    output logic       integration_enable, // integration mode active
    output logic       ram_drive,   // drive the RAM bus
    output logic       ram_req,     // one-cycle RAM access strobe
    output logic       ram_write,   // RAM direction, 1 = write
    output logic       ram_to_tbu,  // 1 = buffer unit RAM
    output logic       ram_tcu_sel, // control unit RAM choice
    output acc_t       ram_tbu_num, // buffer unit number
    output word_t      ram_index,   // RAM way and index
    output word_t      ram_wdata,   // RAM write data
    input  wire word_t ram_rdata    // RAM read data
);

    word_t      ctrl_reg;
    word_t      index_reg;
    word_t      wdata_reg;
    word_t      rdata_reg;
    io_t        testout_reg;
    io_t        pin_out_reg;
    word_t      prdata_reg;
    logic       pslverr_reg;
    logic       sec_s1_reg;
    logic       sec_s2_reg;
    logic       sec_s3_reg;
    logic       sec_level_reg;
    ram_state_e ram_state_reg;
    ram_state_e ram_state_next;
    logic       setup_cyc;
    logic       wr_done;
    logic       index_wr;
    word_t      rd_word;
    logic       rd_hit;

    // offset decode, used for the error answer; the read mux decodes with its own case
    function automatic logic mapped(input addr_t a);
        return (a == `ITC_OFF_CTRL) || (a == `ITC_OFF_INPUT) || (a == `ITC_OFF_INDEX)
            || (a == `ITC_OFF_TESTOUT) || (a == `ITC_OFF_OBSERVE)
            || (a == `ITC_OFF_WDATA) || (a == `ITC_OFF_RDATA);
    endfunction

    assign setup_cyc = psel && !penable;
    assign wr_done   = psel && penable && pwrite && pready;
    assign index_wr  = wr_done && (paddr == `ITC_OFF_INDEX);

    // read data is latched in setup, so the access phase never waits
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    always_comb begin
        rd_word = `ITC_WORD_RESET;
        rd_hit  = mapped(paddr);
        unique case (paddr)
            `ITC_OFF_CTRL:    rd_word = ctrl_reg & `ITC_CTRL_MASK;
            `ITC_OFF_INPUT:   rd_word = {31'h0000_0000, sec_level_reg};
            `ITC_OFF_INDEX:   rd_word = index_reg;
            `ITC_OFF_TESTOUT: rd_word = {24'h00_0000, testout_reg};
            `ITC_OFF_OBSERVE: rd_word = {24'h00_0000, core_in};
            `ITC_OFF_WDATA:   rd_word = wdata_reg;
            `ITC_OFF_RDATA:   rd_word = rdata_reg;
            default:          rd_word = `ITC_WORD_RESET;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= `ITC_WORD_RESET;
            pslverr_reg <= 1'b0;
        end else if (setup_cyc) begin
            prdata_reg  <= pwrite ? `ITC_WORD_RESET : rd_word;
            pslverr_reg <= !rd_hit;
        end
    end

    // control writes outside the disabled state are the caller's hazard
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `ITC_CTRL_RESET;
        end else if (wr_done && paddr == `ITC_OFF_CTRL) begin
            ctrl_reg <= pwdata & `ITC_CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_reg   <= `ITC_WORD_RESET;
            wdata_reg   <= `ITC_WORD_RESET;
            testout_reg <= `ITC_IO_RESET;
        end else if (wr_done) begin
            if (paddr == `ITC_OFF_INDEX) begin
                index_reg <= pwdata;
            end
            if (paddr == `ITC_OFF_WDATA) begin
                wdata_reg <= pwdata;
            end
            if (paddr == `ITC_OFF_TESTOUT) begin
                testout_reg <= pwdata[`ITC_IO_WIDTH-1:0];
            end
        end
    end

    assign integration_enable = ctrl_reg[`ITC_BIT_ENABLE];

    // pins follow the core unless software has taken them over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_reg <= `ITC_IO_RESET;
        end else begin
            pin_out_reg <= integration_enable ? testout_reg : core_out;
        end
    end
    assign pin_out = pin_out_reg;

    // three stages; level moves only when the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_s1_reg    <= 1'b0;
            sec_s2_reg    <= 1'b0;
            sec_s3_reg    <= 1'b0;
            sec_level_reg <= 1'b0;
        end else begin
            sec_s1_reg <= spniden;
            sec_s2_reg <= sec_s1_reg;
            sec_s3_reg <= sec_s2_reg;
            if (sec_s2_reg == sec_s3_reg) begin
                sec_level_reg <= sec_s3_reg;
            end
        end
    end

    ram_access_decode u_decode (
        .pclk        (pclk),
        .presetn     (presetn),
        .ctrl_word   (ctrl_reg),
        .ram_drive   (ram_drive),
        .ram_write   (ram_write),
        .ram_to_tbu  (ram_to_tbu),
        .ram_tcu_sel (ram_tcu_sel),
        .ram_tbu_num (ram_tbu_num)
    );

    // an index write with RAM drive on starts one access; writes during a busy access only store the index
    always_comb begin
        ram_state_next = ram_state_reg;
        unique case (ram_state_reg)
            RAM_IDLE:    if (index_wr && ram_drive) ram_state_next = RAM_ISSUE;
            RAM_ISSUE:   ram_state_next = RAM_CAPTURE;
            RAM_CAPTURE: ram_state_next = RAM_IDLE;
            default:     ram_state_next = RAM_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_state_reg <= RAM_IDLE;
        end else begin
            ram_state_reg <= ram_state_next;
        end
    end

    assign ram_req   = (ram_state_reg == RAM_ISSUE);
    assign ram_index = index_reg;
    assign ram_wdata = wdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= `ITC_WORD_RESET;
        end else if (ram_state_reg == RAM_CAPTURE && !ram_write) begin
            rdata_reg <= ram_rdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_index_start;
        ram_state_reg == RAM_IDLE && index_wr && ram_drive;
    endsequence

    sequence s_one_strobe;
        ram_req ##1 (!ram_req && ram_state_reg == RAM_CAPTURE) ##1 !ram_req;
    endsequence

    ctrl_write_a: assert property (
        wr_done && paddr == `ITC_OFF_CTRL
        |=> ctrl_reg == ($past(pwdata) & `ITC_CTRL_MASK)
            && integration_enable == $past(pwdata[`ITC_BIT_ENABLE]))
        else $error("control register did not take the written value");

    reserved_zero_a: assert property (
        ctrl_reg[31:`ITC_ACC_MSB+1] == 23'h00_0000)
        else $error("reserved control bits are not zero");

    secdbg_read_a: assert property (
        setup_cyc && !pwrite && paddr == `ITC_OFF_INPUT
        |=> prdata == {31'h0000_0000, $past(sec_level_reg)})
        else $error("input register does not show the debug pin level");

    drive_follow_a: assert property (
        $changed(ctrl_reg[`ITC_BIT_DRIVE]) |=> ram_drive == $past(ctrl_reg[`ITC_BIT_DRIVE]))
        else $error("RAM drive does not follow its control bit");

    tcu_select_a: assert property (
        !ctrl_reg[`ITC_BIT_UNIT] ##1 !ram_to_tbu
        |-> ram_tcu_sel == $past(ctrl_reg[`ITC_ACC_LSB]) && ram_tbu_num == 5'h00)
        else $error("control unit RAM choice wrong or upper access bits used");

    tbu_number_a: assert property (
        ctrl_reg[`ITC_BIT_UNIT]
        |=> ram_to_tbu && ram_tbu_num == ($past(ctrl_reg[`ITC_ACC_MSB:`ITC_ACC_LSB]) & 5'h07))
        else $error("buffer unit number not taken from the access field");

    pin_takeover_a: assert property (
        integration_enable |=> pin_out == $past(testout_reg))
        else $error("pins not driven by the test output register");

    ram_strobe_a: assert property (
        s_index_start |=> s_one_strobe)
        else $error("index write did not give exactly one RAM strobe");

    read_capture_a: assert property (
        ram_req && !ram_write ##1 ram_state_reg == RAM_CAPTURE
        |=> rdata_reg == $past(ram_rdata))
        else $error("RAM read data not captured");

    // bus answer, pin path and RAM side effects
    pready_high_a: assert property (
        pready)
        else $error("ready dropped during a transfer");

    unmapped_err_a: assert property (
        setup_cyc && !mapped(paddr)
        |=> pslverr && prdata == `ITC_WORD_RESET)
        else $error("unmapped offset did not answer with an error");

    mapped_ok_a: assert property (
        setup_cyc && mapped(paddr) |=> !pslverr)
        else $error("mapped offset answered with an error");

    ctrl_hold_a: assert property (
        !(wr_done && paddr == `ITC_OFF_CTRL) |=> $stable(ctrl_reg))
        else $error("control register changed without a write");

    pin_functional_a: assert property (
        !integration_enable |=> pin_out == $past(core_out))
        else $error("pins do not follow the core outside integration mode");

    observe_read_a: assert property (
        setup_cyc && !pwrite && paddr == `ITC_OFF_OBSERVE
        |=> prdata == {24'h00_0000, $past(core_in)})
        else $error("observe register does not show the block inputs");

    index_store_a: assert property (
        index_wr |=> ram_index == $past(pwdata))
        else $error("RAM index not taken from the write");

    no_drive_a: assert property (
        ram_state_reg == RAM_IDLE && index_wr && !ram_drive |=> !ram_req)
        else $error("RAM strobe issued with RAM drive off");

    busy_ignore_a: assert property (
        ram_state_reg != RAM_IDLE && index_wr |=> ram_state_reg != RAM_ISSUE)
        else $error("index write during a busy access started another");

    wdata_store_a: assert property (
        wr_done && paddr == `ITC_OFF_WDATA |=> ram_wdata == $past(pwdata))
        else $error("RAM write data not taken from the write");

endmodule // integration_test_control

// ### rtl/ram_access_decode.sv
// registered decode of the control word into test RAM selects
// assumes the control word comes from a register on the same clock
`include "itc_consts.svh"

module ram_access_decode
    import itc_pkg::*;
(
    input  wire logic  pclk,        // bus clock
    input  wire logic  presetn,     // async reset, active low
    input  wire word_t ctrl_word,   // integration control contents
    output logic       ram_drive,   // drive the RAM bus
    output logic       ram_write,   // access direction, 1 = write
    output logic       ram_to_tbu,  // 1 = buffer unit RAM
    output logic       ram_tcu_sel, // 0 = address cache/prefetch, 1 = macro tlb
    output acc_t       ram_tbu_num  // buffer unit number
);

    // only the low bits name an existing buffer unit
    function automatic acc_t tbu_mask(input acc_t acc);
        acc_t m;
        m = acc_t'((6'd1 << `ITC_TBU_NUM_BITS) - 6'd1);
        return acc & m;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_drive   <= 1'b0;
            ram_write   <= 1'b0;
            ram_to_tbu  <= 1'b0;
            ram_tcu_sel <= 1'b0;
            ram_tbu_num <= 5'h00;
        end else begin
            ram_drive  <= ctrl_word[`ITC_BIT_DRIVE];
            ram_write  <= ctrl_word[`ITC_BIT_WNR];
            ram_to_tbu <= ctrl_word[`ITC_BIT_UNIT];
            // bits above the lowest are ignored toward the control unit
            ram_tcu_sel <= ctrl_word[`ITC_BIT_UNIT] ? 1'b0 : ctrl_word[`ITC_ACC_LSB];
            ram_tbu_num <= ctrl_word[`ITC_BIT_UNIT]
                ? tbu_mask(ctrl_word[`ITC_ACC_MSB:`ITC_ACC_LSB]) : 5'h00;
        end
    end

endmodule // ram_access_decode

// ### verification/integration_test_control_tb.sv
// self-checking bench for the integration test control block
// assumes itc_pkg compiled first and itc_consts.svh on the include path
`include "itc_consts.svh"

module integration_test_control_tb
    import itc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        word_t     wd;
        word_t     rd;
        logic[4:0] flags;
        acc_t      num;
    } row_s;

    logic  pclk, presetn, psel, penable, pwrite, spniden;
    addr_t paddr;
    word_t pwdata, prdata, ram_index, ram_wdata, ram_rdata, rd;
    logic  pready, pslverr, integration_enable, ram_drive, ram_req, ram_write;
    logic  ram_to_tbu, ram_tcu_sel, err;
    io_t   core_out, core_in, pin_out;
    acc_t  ram_tbu_num;
    int    n_fail, checks, pulses;
    row_s  rows[5];

    integration_test_control u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spniden(spniden), .core_out(core_out), .core_in(core_in),
        .pin_out(pin_out), .integration_enable(integration_enable),
        .ram_drive(ram_drive), .ram_req(ram_req), .ram_write(ram_write),
        .ram_to_tbu(ram_to_tbu), .ram_tcu_sel(ram_tcu_sel), .ram_tbu_num(ram_tbu_num),
        .ram_index(ram_index), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input word_t seen, input word_t exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; read data and error taken at the completing edge only
    task automatic apb(input logic wr, input addr_t a, input word_t d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            test_done();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // counts access strobes over the cycles after an index write
    task automatic watch_ram(input logic exp_wr, input word_t exp_idx, input word_t exp_wd);
        pulses = 0;
        repeat (4) begin
            @(negedge pclk);
            if (ram_req === 1'b1) begin
                pulses++;
                chk("ram_write", {31'h0, ram_write}, {31'h0, exp_wr});
                chk("ram_index", ram_index, exp_idx);
                if (exp_wr) chk("ram_wdata", ram_wdata, exp_wd);
            end
        end
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; spniden = 1'b0;
        core_out = 8'h3C; core_in = 8'h96; ram_rdata = 32'hCAFE_0123;
        n_fail = 0; checks = 0;
        rows[0] = '{32'hFFFF_FFFF, 32'h0000_01FF, 5'b11110, 5'h07};
        rows[1] = '{32'h0000_0013, 32'h0000_0013, 5'b11001, 5'h00};
        rows[2] = '{32'h0000_01E3, 32'h0000_01E3, 5'b11000, 5'h00};
        rows[3] = '{32'h0000_005A, 32'h0000_005A, 5'b01010, 5'h05};
        rows[4] = '{32'h0000_0000, 32'h0000_0000, 5'b00000, 5'h00};
        // control writes are made with integration mode both off and on; every one is treated as legal
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ITC_OFF_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0000_0000);
        chk("enable reset", {31'h0, integration_enable}, 32'h0);
        chk("drive reset", {31'h0, ram_drive}, 32'h0);
        // decode table: reserved bits, unit select, ignored access bits
        foreach (rows[i]) begin
            apb(1'b1, `ITC_OFF_CTRL, rows[i].wd);
            repeat (2) @(negedge pclk);
            chk("flags", {27'h0, integration_enable, ram_drive, ram_write, ram_to_tbu,
                ram_tcu_sel}, {27'h0, rows[i].flags});
            chk("tbu_num", {27'h0, ram_tbu_num}, {27'h0, rows[i].num});
            apb(1'b0, `ITC_OFF_CTRL, 32'h0);
            chk("ctrl read", rd, rows[i].rd);
        end
        chk("pin functional", {24'h0, pin_out}, 32'h0000_003C);
        apb(1'b1, `ITC_OFF_TESTOUT, 32'h0000_00A5);
        apb(1'b1, `ITC_OFF_CTRL, 32'h0000_0001);
        repeat (2) @(negedge pclk);
        chk("pin override", {24'h0, pin_out}, 32'h0000_00A5);
        apb(1'b0, `ITC_OFF_OBSERVE, 32'h0);
        chk("observe", rd, 32'h0000_0096);
        chk("mapped err", {31'h0, err}, 32'h0);
        // debug pin through the synchroniser, write to read-only ignored
        spniden <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b1, `ITC_OFF_INPUT, 32'hFFFF_FFFE);
        apb(1'b0, `ITC_OFF_INPUT, 32'h0);
        chk("input pin high", rd, 32'h0000_0001);
        spniden <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, `ITC_OFF_INPUT, 32'h0);
        chk("input pin low", rd, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        // drive off: index write starts nothing
        apb(1'b1, `ITC_OFF_CTRL, 32'h0000_0005);
        apb(1'b1, `ITC_OFF_INDEX, 32'h0000_0011);
        watch_ram(1'b1, 32'h0000_0011, 32'h0);
        chk("no strobe", pulses, 32'h0);
        // control unit read
        apb(1'b1, `ITC_OFF_CTRL, 32'h0000_0013);
        apb(1'b1, `ITC_OFF_INDEX, 32'hC001_2345);
        watch_ram(1'b0, 32'hC001_2345, 32'h0);
        chk("read strobe", pulses, 32'h1);
        apb(1'b0, `ITC_OFF_RDATA, 32'h0);
        chk("ram rdata", rd, 32'hCAFE_0123);
        // buffer unit write
        apb(1'b1, `ITC_OFF_CTRL, 32'h0000_006E);
        apb(1'b1, `ITC_OFF_WDATA, 32'h5A5A_F00D);
        apb(1'b1, `ITC_OFF_INDEX, 32'h0000_007F);
        watch_ram(1'b1, 32'h0000_007F, 32'h5A5A_F00D);
        chk("write strobe", pulses, 32'h1);
        chk("tbu write num", {27'h0, ram_tbu_num}, 32'h6);
        // system reset closes integration testing; set bits first so it has work to do
        apb(1'b1, `ITC_OFF_CTRL, 32'h0000_0003);
        repeat (2) @(negedge pclk);
        chk("enable before reset", {31'h0, integration_enable}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("enable after reset", {31'h0, integration_enable}, 32'h0);
        chk("drive after reset", {31'h0, ram_drive}, 32'h0);
        apb(1'b0, `ITC_OFF_CTRL, 32'h0);
        chk("ctrl after reset", rd, 32'h0);
        test_done();
    end
endmodule // integration_test_control_tb
